// >>> src/pmc_top.sv
// port power-management capability and control/status register bank
//
// Register access over AXI4-Lite is this design's own decision.
module pmc_top #(
   parameter bit IS_UPSTREAM = 1'b0
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic hot_reset,
   input wire logic own_wake_event,
   input wire logic fwd_wake_event,
   input wire logic in_d3_cold,
   input wire logic [11:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [11:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   output logic wake_msg_req,
   output logic [1:0] power_state_field,
   output logic keep_context_on_wake,
   output logic irq
);
   pmc_wr_if wbus();

   logic [4:0] mask_r, mask_nxt;
   logic [1:0] ps_r, ps_nxt;
   logic keep_r, keep_nxt;
   logic wen_r, wen_nxt;
   logic wst_r, wst_nxt;
   logic unlock_r, unlock_nxt;
   logic [pmc_pkg::PMC_IRQ_N-1:0] ist_r, ist_nxt, imask_r, imask_nxt;
   logic own_s1_r, own_s2_r, own_s3_r;
   logic fwd_s1_r, fwd_s2_r;
   logic cold_s1_r, cold_s2_r;
   logic hot_s1_r, hot_s2_r;
   logic own_pulse;
   logic wake_r, wake_nxt;
   logic ar_r, ar_nxt;
   logic [31:0] rd_r, rd_nxt;
   logic [1:0] rresp_r, rresp_nxt;
   logic [1:0] bresp_r, bresp_nxt;
   logic [31:0] cap_val, csr_val, wd;
   logic w_cap, w_csr, w_lock, w_ist, w_imask;

   // write channel front end
   pmc_axil_wr u_wr (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .s_awaddr(s_awaddr),
      .s_awvalid(s_awvalid),
      .s_awready(s_awready),
      .s_wdata(s_wdata),
      .s_wstrb(s_wstrb),
      .s_wvalid(s_wvalid),
      .s_wready(s_wready),
      .s_bvalid(s_bvalid),
      .s_bready(s_bready),
      .wr_o(wbus)
   );

   // pin inputs pass two flops before use; stage three only for the edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         own_s1_r <= 1'b0;
         own_s2_r <= 1'b0;
         own_s3_r <= 1'b0;
         fwd_s1_r <= 1'b0;
         fwd_s2_r <= 1'b0;
         cold_s1_r <= 1'b0;
         cold_s2_r <= 1'b0;
         hot_s1_r <= 1'b0;
         hot_s2_r <= 1'b0;
      end else if (ce) begin
         own_s1_r <= own_wake_event;
         own_s2_r <= own_s1_r;
         own_s3_r <= own_s2_r;
         fwd_s1_r <= fwd_wake_event;
         fwd_s2_r <= fwd_s1_r;
         cold_s1_r <= in_d3_cold;
         cold_s2_r <= cold_s1_r;
         hot_s1_r <= hot_reset;
         hot_s2_r <= hot_s1_r;
      end
   end

   // rising edge of the port's own wake event; none on the upstream port
   assign own_pulse = own_s2_r & ~own_s3_r & ~IS_UPSTREAM;

   // byte-lane merge of the write data; lanes with strobe low keep zero
   always_comb begin
      wd = 32'h00000000;
      for (int i = 0; i < 4; i++) begin
         if (wbus.strb[i]) begin
            wd[i*8 +: 8] = wbus.data[i*8 +: 8];
         end
      end
   end

   assign w_cap = wbus.wr && wbus.addr == pmc_pkg::PMC_CAP_OFS;
   assign w_csr = wbus.wr && wbus.addr == pmc_pkg::PMC_CSR_OFS;
   assign w_lock = wbus.wr && wbus.addr == pmc_pkg::PMC_LOCK_OFS;
   assign w_ist = wbus.wr && wbus.addr == pmc_pkg::PMC_IRQ_STAT_OFS;
   assign w_imask = wbus.wr && wbus.addr == pmc_pkg::PMC_IRQ_MASK_OFS;

   // register next values; unlisted bits have no storage and read zero
   always_comb begin
      mask_nxt = mask_r;
      ps_nxt = ps_r;
      keep_nxt = keep_r;
      wen_nxt = wen_r;
      wst_nxt = wst_r;
      unlock_nxt = unlock_r;
      ist_nxt = ist_r;
      imask_nxt = imask_r;
      if (w_lock && wbus.strb[0]) begin
         unlock_nxt = wbus.data[0];
      end
      // lockable fields take writes only while the write path is open
      if (w_cap && unlock_r && wbus.strb[3]) begin
         mask_nxt = wd[pmc_pkg::PMC_MASK_MSB:pmc_pkg::PMC_MASK_LSB];
      end
      if (w_csr && wbus.strb[0]) begin
         ps_nxt = wd[pmc_pkg::PMC_PS_MSB:pmc_pkg::PMC_PS_LSB];
         if (unlock_r) begin
            keep_nxt = wd[pmc_pkg::PMC_KEEP_BIT];
         end
      end
      if (w_csr && wbus.strb[1]) begin
         wen_nxt = wd[pmc_pkg::PMC_WEN_BIT];
         if (wd[pmc_pkg::PMC_WST_BIT]) begin
            wst_nxt = 1'b0;
         end
      end
      // own event wins over a same-cycle clear; forwarded ones never set
      if (own_pulse) begin
         wst_nxt = 1'b1;
      end
      if (w_ist && wbus.strb[0]) begin
         ist_nxt = ist_r & ~wbus.data[pmc_pkg::PMC_IRQ_N-1:0];
      end
      if (w_imask && wbus.strb[0]) begin
         imask_nxt = wbus.data[pmc_pkg::PMC_IRQ_N-1:0];
      end
      if (own_pulse) begin
         ist_nxt[pmc_pkg::PMC_IRQ_WAKE] = 1'b1;
      end
      if (w_csr && wbus.strb[0] && ps_nxt != ps_r) begin
         ist_nxt[pmc_pkg::PMC_IRQ_PSCHG] = 1'b1;
      end
      // hot reset resets power state, keep-context, mask and unlock; sticky wake bits and irq bits survive it
      if (hot_s2_r) begin
         ps_nxt = pmc_pkg::PMC_PS_D0;
         keep_nxt = pmc_pkg::PMC_KEEP_RST;
         mask_nxt = pmc_pkg::PMC_MASK_RST;
         unlock_nxt = 1'b0; // wen_r untouched
      end
   end

   // register state; of the two resets only aresetn clears the sticky bits
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask_r <= pmc_pkg::PMC_MASK_RST;
         ps_r <= pmc_pkg::PMC_PS_D0;
         keep_r <= pmc_pkg::PMC_KEEP_RST;
         wen_r <= 1'b0;
         wst_r <= 1'b0;
         unlock_r <= 1'b0;
         ist_r <= '0;
         imask_r <= '0;
      end else if (ce) begin
         mask_r <= mask_nxt;
         ps_r <= ps_nxt;
         keep_r <= keep_nxt;
         wen_r <= wen_nxt;
         wst_r <= wst_nxt;
         unlock_r <= unlock_nxt;
         ist_r <= ist_nxt;
         imask_r <= imask_nxt;
      end
   end

   // wake messages follow the fixed reset mask, never the readback copy
   always_comb begin
      wake_nxt = 1'b0;
      if ((own_pulse || fwd_s2_r) && wen_r && !cold_s2_r) begin
         wake_nxt = 1'b1;
      end
      if (ps_r == pmc_pkg::PMC_PS_D0 && !pmc_pkg::PMC_MASK_RST[0]) begin
         wake_nxt = 1'b0;
      end
      if (ps_r == pmc_pkg::PMC_PS_D3HOT && !pmc_pkg::PMC_MASK_RST[3]) begin
         wake_nxt = 1'b0;
      end
   end

   // wake request register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wake_r <= 1'b0;
      end else if (ce) begin
         wake_r <= wake_nxt;
      end
   end

   // readback images; reserved and absent fields are constant zero
   always_comb begin
      cap_val = pmc_pkg::PMC_CAP_LOW;
      cap_val[pmc_pkg::PMC_D2_BIT] = 1'b0;
      cap_val[pmc_pkg::PMC_MASK_MSB:pmc_pkg::PMC_MASK_LSB] = mask_r;
      csr_val = 32'h00000000;
      csr_val[pmc_pkg::PMC_PS_MSB:pmc_pkg::PMC_PS_LSB] = ps_r;
      csr_val[pmc_pkg::PMC_KEEP_BIT] = keep_r;
      csr_val[pmc_pkg::PMC_WEN_BIT] = wen_r;
      csr_val[pmc_pkg::PMC_WST_BIT] = wst_r;
   end

   // read channel: one read at a time, answer one cycle after address
   assign s_arready = ~ar_r;
   always_comb begin
      ar_nxt = ar_r;
      rd_nxt = rd_r;
      rresp_nxt = rresp_r;
      if (ar_r && s_rready) begin
         ar_nxt = 1'b0;
      end
      if (s_arvalid && !ar_r) begin
         ar_nxt = 1'b1;
         rresp_nxt = pmc_pkg::PMC_RESP_OK;
         unique case (s_araddr)
            pmc_pkg::PMC_CAP_OFS: rd_nxt = cap_val;
            pmc_pkg::PMC_CSR_OFS: rd_nxt = csr_val;
            pmc_pkg::PMC_LOCK_OFS: rd_nxt = {31'h0, unlock_r};
            pmc_pkg::PMC_IRQ_STAT_OFS: rd_nxt = {30'h0, ist_r};
            pmc_pkg::PMC_IRQ_MASK_OFS: rd_nxt = {30'h0, imask_r};
            default: begin
               rd_nxt = 32'h00000000;
               rresp_nxt = pmc_pkg::PMC_RESP_SLVERR;
            end
         endcase
      end
   end

   // write response code decided when the write fires
   always_comb begin
      bresp_nxt = bresp_r;
      if (wbus.wr) begin
         bresp_nxt = (w_cap || w_csr || w_lock || w_ist || w_imask) ?
            pmc_pkg::PMC_RESP_OK : pmc_pkg::PMC_RESP_SLVERR;
      end
   end

   // bus response registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ar_r <= 1'b0;
         rd_r <= 32'h00000000;
         rresp_r <= pmc_pkg::PMC_RESP_OK;
         bresp_r <= pmc_pkg::PMC_RESP_OK;
      end else if (ce) begin
         ar_r <= ar_nxt;
         rd_r <= rd_nxt;
         rresp_r <= rresp_nxt;
         bresp_r <= bresp_nxt;
      end
   end

   assign s_rvalid = ar_r;
   assign s_rdata = rd_r;
   assign s_rresp = rresp_r;
   assign s_bresp = bresp_r;
   assign wake_msg_req = wake_r;
   assign power_state_field = ps_r;
   assign keep_context_on_wake = keep_r;
   assign irq = |(ist_r & imask_r);
endmodule : pmc_top

// >>> src/pmc_pkg.sv
// package for the port power-management capability and control/status block
// Function
// - capability bit 26 reads zero; second low-power state unsupported.
// - wake-support mask bits 31:27 reset 0b11001, writable only when unlocked.
// - mask writes change readback only; wake generation follows reset value.
// - no wake messages forwarded while in cold D3.
// - power state bits 1:0 read/write; 0 is D0, 3 is hot D3, 1/2 reserved.
// - keep-context bit 3 resets to one, context kept on hot D3 to D0.
// - wake-enable bit 8 is sticky, resets zero, enables wake messages.
// - hot reset leaves wake-enable unchanged.
// - sticky wake-status bit 15 sets on own wake event, cleared by writing one.
// - wake-status not set when only propagating a foreign wake message.
// - on the upstream port wake-status always stays zero.
// - data-select, data-scale and data fields read zero.
// - bus power state support bit 22 and clock control bit 23 read zero.
package pmc_pkg;
   localparam logic [11:0] PMC_CAP_OFS = 12'h0C0;
   localparam logic [11:0] PMC_CSR_OFS = 12'h0C4;
   localparam logic [11:0] PMC_LOCK_OFS = 12'h0E0;
   localparam logic [11:0] PMC_IRQ_STAT_OFS = 12'h0E4;
   localparam logic [11:0] PMC_IRQ_MASK_OFS = 12'h0E8;
   localparam int PMC_D2_BIT = 26;
   localparam int PMC_MASK_LSB = 27;
   localparam int PMC_MASK_MSB = 31;
   localparam logic [4:0] PMC_MASK_RST = 5'h19;
   localparam int PMC_PS_LSB = 0;
   localparam int PMC_PS_MSB = 1;
   localparam int PMC_KEEP_BIT = 3;
   localparam logic PMC_KEEP_RST = 1'b1;
   localparam int PMC_WEN_BIT = 8;
   localparam int PMC_WST_BIT = 15;
   localparam logic [1:0] PMC_PS_D0 = 2'h0;
   localparam logic [1:0] PMC_PS_D3HOT = 2'h3;
   localparam logic [31:0] PMC_CAP_LOW = 32'h00030001;
   localparam logic [1:0] PMC_RESP_OK = 2'h0;
   localparam logic [1:0] PMC_RESP_SLVERR = 2'h2;
   // interrupt status bits: wake status set, power state changed
   localparam int PMC_IRQ_WAKE = 0;
   localparam int PMC_IRQ_PSCHG = 1;
   localparam int PMC_IRQ_N = 2;
endpackage : pmc_pkg

// >>> src/pmc_wr_if.sv
// interface carrying a decoded register write between bus slave and core
interface pmc_wr_if;
   logic wr;
   logic [11:0] addr;
   logic [31:0] data;
   logic [3:0] strb;
   modport slave(output wr, output addr, output data, output strb);
   modport core(input wr, input addr, input data, input strb);
endinterface : pmc_wr_if

// >>> src/pmc_axil_wr.sv
// axi4-lite write channel front end producing one write pulse
module pmc_axil_wr (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [11:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic s_bvalid,
   input wire logic s_bready,
   pmc_wr_if.slave wr_o
);
   logic aw_r, aw_nxt, w_r, w_nxt, b_r, b_nxt;
   logic [11:0] a_r, a_nxt;
   logic [31:0] d_r, d_nxt;
   logic [3:0] s_r, s_nxt;
   logic go;

   // address and data latch independently; response after both are held
   assign s_awready = ~aw_r & ~b_r;
   assign s_wready = ~w_r & ~b_r;
   assign s_bvalid = b_r;
   assign go = aw_r & w_r & ~b_r;
   assign wr_o.wr = go & ce;
   assign wr_o.addr = a_r;
   assign wr_o.data = d_r;
   assign wr_o.strb = s_r;

   // next-state for the write channel
   always_comb begin
      aw_nxt = aw_r;
      w_nxt = w_r;
      b_nxt = b_r;
      a_nxt = a_r;
      d_nxt = d_r;
      s_nxt = s_r;
      if (s_awvalid && s_awready) begin
         aw_nxt = 1'b1;
         a_nxt = s_awaddr;
      end
      if (s_wvalid && s_wready) begin
         w_nxt = 1'b1;
         d_nxt = s_wdata;
         s_nxt = s_wstrb;
      end
      if (go) begin
         aw_nxt = 1'b0;
         w_nxt = 1'b0;
         b_nxt = 1'b1;
      end
      if (b_r && s_bready) begin
         b_nxt = 1'b0;
      end
   end

   // registers frozen while ce is low
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_r <= 1'b0;
         w_r <= 1'b0;
         b_r <= 1'b0;
         a_r <= 12'h000;
         d_r <= 32'h00000000;
         s_r <= 4'h0;
      end else if (ce) begin
         aw_r <= aw_nxt;
         w_r <= w_nxt;
         b_r <= b_nxt;
         a_r <= a_nxt;
         d_r <= d_nxt;
         s_r <= s_nxt;
      end
   end
endmodule : pmc_axil_wr

// >>> sim/pmc_chk.sv
// assertion checker for the power-management register bank ports
module pmc_chk (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic in_d3_cold,
   input wire logic s_awvalid,
   input wire logic s_awready,
   input wire logic s_wvalid,
   input wire logic s_wready,
   input wire logic s_bvalid,
   input wire logic s_arvalid,
   input wire logic s_arready,
   input wire logic [31:0] s_rdata,
   input wire logic [1:0] s_rresp,
   input wire logic s_rvalid,
   input wire logic s_rready,
   input wire logic wake_msg_req,
   input wire logic [1:0] power_state_field,
   input wire logic keep_context_on_wake
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge aclk);
   endclocking
   // a frozen block proves nothing, so clock enable gates the checks too
   default disable iff (!aresetn || !ce);
   rst_vals_a: assert property (disable iff (1'h0)
      !aresetn && ce |=> keep_context_on_wake && power_state_field == 2'h0)
      else $error("bad reset values");
   rd_answer_a: assert property (
      s_arvalid && s_arready |=> s_rvalid) else $error("read not answered");
   rd_hold_a: assert property (
      s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
      else $error("read data dropped");
   wr_answer_a: assert property (
      s_awvalid && s_awready && s_wvalid && s_wready |=> ##1 s_bvalid)
      else $error("write not answered");
   err_data_a: assert property (
      s_rvalid && s_rresp == 2'h2 |-> s_rdata == 32'h0)
      else $error("error read not zero");
   // the cold pin passes a sync chain, so allow it to settle first
   cold_quiet_a: assert property (
      in_d3_cold [*4] |-> !wake_msg_req) else $error("wake sent cold");
   state_cause_a: assert property (
      $changed(power_state_field) |->
      $rose(s_bvalid) || power_state_field == 2'h0)
      else $error("state moved alone");
   keep_cause_a: assert property (
      $changed(keep_context_on_wake) |->
      $rose(s_bvalid) || keep_context_on_wake)
      else $error("context bit moved alone");
   wr_c: cover property (s_awvalid && s_awready);
   rd_c: cover property (s_rvalid && s_rready);
   rd_wait_c: cover property (s_rvalid && !s_rready);
   wake_c: cover property (wake_msg_req);
endmodule : pmc_chk

// >>> sim/testbench.sv
// self-checking bench for the power-management register bank
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [11:0] CAP = pmc_pkg::PMC_CAP_OFS;
   localparam logic [11:0] CSR = pmc_pkg::PMC_CSR_OFS;
   localparam logic [1:0] OK = pmc_pkg::PMC_RESP_OK;
   localparam logic [1:0] ER = pmc_pkg::PMC_RESP_SLVERR;
   logic aclk = 1'h0, aresetn = 1'h0, ce = 1'h1, in_d3_cold = 1'h0;
   logic [2:0] drv = 3'h0;
   wire logic hot_reset = drv[2];
   wire logic own_wake_event = drv[1];
   wire logic fwd_wake_event = drv[0];
   logic [11:0] s_awaddr = 12'h000, s_araddr = 12'h000;
   logic [31:0] s_wdata = 32'h0, s_rdata, rd_v;
   logic [3:0] s_wstrb = 4'hF;
   logic s_awvalid = 1'h0, s_wvalid = 1'h0, s_bready = 1'h0;
   logic s_arvalid = 1'h0, s_rready = 1'h0, va, vw;
   logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, irq;
   logic wake_msg_req, keep_context_on_wake;
   logic [1:0] s_bresp, s_rresp, power_state_field, rsp;
   int n_errors = 0, checks = 0, n_msg = 0, n0;
   logic up_irq;
   pmc_top u_dut (.*);
   // upstream-strapped copy on the same bus; its own events must stay silent
   pmc_top #(.IS_UPSTREAM(1'b1)) u_up (.*, .s_awready(), .s_wready(),
      .s_bresp(), .s_bvalid(), .s_arready(), .s_rdata(), .s_rresp(),
      .s_rvalid(), .wake_msg_req(), .power_state_field(),
      .keep_context_on_wake(), .irq(up_irq));
   // events waited on: write handshake, arready, rvalid, bvalid
   wire logic [3:0] ev = {s_awvalid & s_awready | s_wvalid & s_wready,
      s_arready, s_rvalid, s_bvalid};
   always #10 aclk = ~aclk;
   // tally outgoing wake requests
   always @(posedge aclk) if (wake_msg_req === 1'h1) n_msg <= n_msg + 1;
   task automatic results;
      if (n_errors == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : results
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch at %0t: got %h want %h", $time, g, e);
      end
   endtask : chk
   task automatic pin(input logic g, input logic e);
      chk({31'h0, g}, {31'h0, e});
   endtask : pin
   // sampled at the falling edge so the handshake edge is unambiguous
   task automatic till(input int k);
      int n;
      n = 0;
      do begin
         @(negedge aclk);
         n++;
         if (n > 40) begin
            n_errors++;
            results();
         end
      end while (ev[k] !== 1'h1);
   endtask : till
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
      input logic [1:0] r);
      s_awaddr <= a;
      s_wdata <= d;
      s_awvalid <= 1'h1;
      s_wvalid <= 1'h1;
      va = 1'h1;
      vw = 1'h1;
      while (va || vw) begin
         till(3);
         va = va && !s_awready;
         vw = vw && !s_wready;
         @(posedge aclk);
         s_awvalid <= va;
         s_wvalid <= vw;
      end
      till(0);
      // ready comes one edge late, so the response must stand meanwhile
      @(posedge aclk);
      s_bready <= 1'h1;
      @(negedge aclk);
      rsp = s_bresp;
      @(posedge aclk);
      s_bready <= 1'h0;
      chk({30'h0, rsp}, {30'h0, r});
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] e,
      input logic [1:0] r);
      s_araddr <= a;
      s_arvalid <= 1'h1;
      till(2);
      @(posedge aclk);
      s_arvalid <= 1'h0;
      till(1);
      // ready comes one edge late, so read data must stand meanwhile
      @(posedge aclk);
      s_rready <= 1'h1;
      @(negedge aclk);
      rd_v = s_rdata;
      rsp = s_rresp;
      @(posedge aclk);
      s_rready <= 1'h0;
      chk(rd_v, e);
      chk({30'h0, rsp}, {30'h0, r});
   endtask : rd
   // pins pass a sync chain, so give the event time to land
   task automatic pulse(input int b, input int c);
      drv[b] <= 1'h1;
      repeat (c) @(posedge aclk);
      drv[b] <= 1'h0;
      repeat (8) @(posedge aclk);
   endtask : pulse
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      pin(keep_context_on_wake, 1'h1);
      chk({30'h0, power_state_field}, 32'h0);
      rd(CAP, 32'hC8030001, OK);
      rd(CSR, 32'h00000008, OK);
      // every power code, with all other bits but keep-context bit 3 thrown at the register
      for (int i = 0; i < 4; i++) begin
         wr(CSR, 32'hFFFFFFF4 | i, OK);
         rd(CSR, 32'h00000108 | i, OK);
         chk({30'h0, power_state_field}, i);
      end
      rd(pmc_pkg::PMC_IRQ_STAT_OFS, 32'h2, OK);
      wr(CAP, 32'h0, OK);
      rd(CAP, 32'hC8030001, OK);
      wr(pmc_pkg::PMC_LOCK_OFS, 32'h1, OK);
      wr(CAP, 32'h07FFFFFF, OK);
      rd(CAP, 32'h00030001, OK);
      wr(CSR, 32'h00000100, OK);
      rd(CSR, 32'h00000100, OK);
      wr(pmc_pkg::PMC_IRQ_STAT_OFS, 32'h3, OK);
      wr(pmc_pkg::PMC_IRQ_MASK_OFS, 32'h1, OK);
      pin(irq, 1'h0);
      n0 = n_msg;
      pulse(1, 2);
      chk(n_msg, n0 + 1);
      pin(irq, 1'h1);
      pin(up_irq, 1'h0);
      rd(CSR, 32'h00008100, OK);
      wr(CSR, 32'h00008100, OK);
      rd(CSR, 32'h00000100, OK);
      wr(pmc_pkg::PMC_IRQ_STAT_OFS, 32'h1, OK);
      pin(irq, 1'h0);
      pulse(0, 1);
      chk(n_msg, n0 + 2);
      rd(CSR, 32'h00000100, OK);
      // with ce low the pin chain is frozen, so a forwarded wake is lost
      ce <= 1'h0;
      pulse(0, 1);
      ce <= 1'h1;
      chk(n_msg, n0 + 2);
      in_d3_cold <= 1'h1;
      repeat (4) @(posedge aclk);
      pulse(1, 2);
      pulse(0, 1);
      chk(n_msg, n0 + 2);
      in_d3_cold <= 1'h0;
      wr(CSR, 32'h00008003, OK);
      pulse(1, 2);
      chk(n_msg, n0 + 2);
      rd(CSR, 32'h00008003, OK);
      wr(CSR, 32'h00000103, OK);
      pulse(2, 3);
      pin(keep_context_on_wake, 1'h1);
      rd(CSR, 32'h00008108, OK);
      rd(CAP, 32'hC8030001, OK);
      wr(12'h010, 32'hFFFFFFFF, ER);
      rd(12'h010, 32'h0, ER);
      results();
   end
endmodule : testbench
bind pmc_top pmc_chk u_chk (.*);
